/* File: hdl/pmt8_consts.vh */
`ifndef PMT8_CONSTS_VH
`define PMT8_CONSTS_VH
`define PMT8_ADDR_W        4
`define PMT8_OFS_COUNT     4'h0
`define PMT8_OFS_PERIOD    4'h4
`define PMT8_OFS_CONTROL   4'h8
`define PMT8_OFS_STATUS    4'hC
`define PMT8_CTL_PRE_LSB   0
`define PMT8_CTL_RUN_BIT   2
`define PMT8_CTL_POST_LSB  3
`define PMT8_CTL_MASK      8'h7F
`define PMT8_COUNT_RST     8'h00
`define PMT8_PERIOD_RST    8'hFF
`define PMT8_CTL_RST       8'h00
`define PMT8_INSTR_DIV     2'h3
`define PMT8_STAT_MATCH    0
`define PMT8_STAT_ENABLE   8
`define PMT8_RESP_OKAY     2'h0
`define PMT8_RESP_SLVERR   2'h2
`endif

/* File: hdl/pmt8_timer.v */
`timescale 1ns/1ns
`include "pmt8_consts.vh"
module pmt8_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sleep,
  output reg         match_pulse,
  output reg         ccp_time_base,
  output reg         spi_shift_clk,
  output wire        irq
);
  reg  [1:0] instr_div_r;
  reg  [5:0] pre_cnt_r;
  reg  [3:0] post_cnt_r;
  reg  [7:0] tick_count_r;
  reg  [7:0] period_limit_r;
  reg  [7:0] timer_control_r;
  reg        match_irq_flag_r;
  reg        match_irq_enable_r;
  reg        aw_hold_r;
  reg        w_hold_r;
  reg  [3:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg        w_lane0_r;
  reg        w_lane1_r;
  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       aw_have = aw_hold_r | aw_take;
  wire       w_have  = w_hold_r | w_take;
  wire       do_wr   = aw_have & w_have & ~s_axi_bvalid;
  wire [3:0] wa      = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd     = w_hold_r ? w_data_r : s_axi_wdata;
  wire       wl0     = w_hold_r ? w_lane0_r : s_axi_wstrb[0];
  wire       wl1     = w_hold_r ? w_lane1_r : s_axi_wstrb[1];
  wire       wr_cnt  = do_wr & (wa == `PMT8_OFS_COUNT) & wl0;
  wire       wr_per  = do_wr & (wa == `PMT8_OFS_PERIOD) & wl0;
  wire       wr_ctl  = do_wr & (wa == `PMT8_OFS_CONTROL) & wl0;
  wire       wr_st   = do_wr & (wa == `PMT8_OFS_STATUS);
  wire       run     = timer_control_r[`PMT8_CTL_RUN_BIT];
  wire [1:0] pre_sel = timer_control_r[`PMT8_CTL_PRE_LSB +: 2];
  wire [3:0] post_sel = timer_control_r[`PMT8_CTL_POST_LSB +: 4];
  // instruction clock enable: one aclk cycle in four
  wire       instr_tick = (instr_div_r == `PMT8_INSTR_DIV);
  reg  [5:0] pre_top;
  wire       active  = run & ~sleep;
  wire       cnt_tick = active & instr_tick & (pre_cnt_r == pre_top);
  wire       is_match = cnt_tick & (tick_count_r == period_limit_r);
  wire       post_done = is_match & (post_cnt_r == post_sel);

  always @* begin
    case (pre_sel)
      2'h0:    pre_top = 6'h00;
      2'h1:    pre_top = 6'h03;
      2'h2:    pre_top = 6'h0F;
      default: pre_top = 6'h3F;
    endcase
  end

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign irq = match_irq_flag_r & match_irq_enable_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_div_r <= 2'h0;
    end else if (!sleep) begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  // prescaler and postscaler
  always @(posedge aclk) begin
    if (!aresetn || wr_cnt || wr_ctl) begin
      pre_cnt_r  <= 6'h00;
      post_cnt_r <= 4'h0;
    end else begin
      if (active && instr_tick) begin
        pre_cnt_r <= (pre_cnt_r == pre_top) ? 6'h00 : pre_cnt_r + 6'h01;
      end
      if (is_match) begin
        post_cnt_r <= post_done ? 4'h0 : post_cnt_r + 4'h1;
      end
    end
  end

  // count register; a software write wins over a same-cycle count step
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_count_r <= `PMT8_COUNT_RST;
    end else if (wr_cnt) begin
      tick_count_r <= wd[7:0];
    end else if (is_match) begin
      tick_count_r <= 8'h00;
    end else if (cnt_tick) begin
      tick_count_r <= tick_count_r + 8'h01;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      period_limit_r     <= `PMT8_PERIOD_RST;
      timer_control_r    <= `PMT8_CTL_RST;
      match_irq_flag_r   <= 1'b0;
      match_irq_enable_r <= 1'b0;
    end else begin
      if (wr_per) begin
        period_limit_r <= wd[7:0];
      end
      if (wr_ctl) begin
        timer_control_r <= wd[7:0] & `PMT8_CTL_MASK;
      end
      // set wins over a clear in the same cycle
      if (post_done) begin
        match_irq_flag_r <= 1'b1;
      end else if (wr_st && wl0 && wd[`PMT8_STAT_MATCH]) begin
        match_irq_flag_r <= 1'b0;
      end
      if (wr_st && wl1) begin
        match_irq_enable_r <= wd[`PMT8_STAT_ENABLE];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      match_pulse   <= 1'b0;
      ccp_time_base <= 1'b0;
      spi_shift_clk <= 1'b0;
    end else begin
      match_pulse   <= is_match;
      ccp_time_base <= is_match;
      spi_shift_clk <= is_match;
    end
  end

  // write channel: address and data taken in either order, held until both seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_data_r     <= 32'h00000000;
      w_lane0_r    <= 1'b0;
      w_lane1_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMT8_RESP_OKAY;
    end else begin
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa[1:0] != 2'h0) ? `PMT8_RESP_SLVERR : `PMT8_RESP_OKAY;
      end else begin
        if (aw_take) begin
          aw_hold_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_r  <= 1'b1;
          w_data_r  <= s_axi_wdata;
          w_lane0_r <= s_axi_wstrb[0];
          w_lane1_r <= s_axi_wstrb[1];
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read channel: one cycle to answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PMT8_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PMT8_RESP_OKAY;
      case (s_axi_araddr)
        `PMT8_OFS_COUNT:   s_axi_rdata <= {24'h000000, tick_count_r};
        `PMT8_OFS_PERIOD:  s_axi_rdata <= {24'h000000, period_limit_r};
        `PMT8_OFS_CONTROL: s_axi_rdata <= {24'h000000, timer_control_r};
        `PMT8_OFS_STATUS:  s_axi_rdata <= {23'h000000, match_irq_enable_r,
                                           7'h00, match_irq_flag_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PMT8_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pmt8_timer

/* File: verif/pmt8_timer_chk.sv */
`timescale 1ns/1ns
module pmt8_chk (
  input logic        aclk, aresetn, sleep, match_pulse, ccp_time_base, spi_shift_clk,
  input logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input logic        s_axi_rvalid, s_axi_rready,
  input logic [1:0]  s_axi_bresp,
  input logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_in;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // fastest setting steps every 4 clocks, so pulses can never be closer
  sequence quiet3;
    !match_pulse[*3];
  endsequence
  pulse_gap_a: assert property (match_pulse |=> quiet3)
    else $error("match pulses too close");
  ccp_copy_a: assert property (ccp_time_base == match_pulse)
    else $error("time base differs from match");
  spi_copy_a: assert property (spi_shift_clk == match_pulse)
    else $error("shift clock differs from match");
  sleep_hold_a: assert property ($past(sleep) |-> !match_pulse)
    else $error("match pulse while asleep");
  wr_resp_a: assert property (wr_in |=> s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
endmodule // pmt8_chk
bind pmt8_timer pmt8_chk pmt8_chk_inst (.*);

/* File: verif/period_match_timer8_test.sv */
`timescale 1ns/1ns
`include "pmt8_consts.vh"
module period_match_timer8_test;
  logic        aclk=0, aresetn=0, sleep=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
  logic        s_axi_arvalid=0, s_axi_rready=0;
  logic [3:0]  s_axi_awaddr=0, s_axi_araddr=0, s_axi_wstrb=4'hF;
  logic [31:0] s_axi_wdata=0, q;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         match_pulse, ccp_time_base, spi_shift_clk, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          miscompares=0, n_compared=0, g, i, p;
  pmt8_timer pmt8_timer_inst (.*);
  initial forever #25 aclk = ~aclk;
  task results; begin
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  task chk(input string nm, input logic [31:0] s, e); begin
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  end endtask
  // ready is sampled at the falling edge, so release follows the taking edge
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hr;
    begin
      @(posedge aclk);
      if (w) begin
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      end else begin
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      end
      for (n = 0; n < 50; n++) begin
        @(negedge aclk);
        ha = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
        hw = s_axi_wvalid & s_axi_wready;
        hr = w ? s_axi_bvalid : s_axi_rvalid;
        q = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
        if (ha) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
        if (hw) s_axi_wvalid <= 0;
        if (hr) begin s_axi_bready <= 0; s_axi_rready <= 0; break; end
      end
      if (n == 50) begin miscompares++; results; end
    end
  endtask
  task pw; begin
    for (g = 0; g < 2000; g++) begin
      @(negedge aclk);
      if (match_pulse === 1'b1) break;
    end
    if (g == 2000) begin miscompares++; results; end
  end endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    acc(0, `PMT8_OFS_COUNT, 0); chk("count", q, 0);
    acc(0, `PMT8_OFS_PERIOD, 0); chk("period", q, 32'hFF);
    acc(0, `PMT8_OFS_CONTROL, 0); chk("control", q, 0);
    acc(1, `PMT8_OFS_CONTROL, 32'hFF); acc(0, `PMT8_OFS_CONTROL, 0); chk("ctl", q, 32'h7F);
    acc(1, `PMT8_OFS_PERIOD, 32'h5A); acc(0, `PMT8_OFS_PERIOD, 0); chk("period", q, 32'h5A);
    acc(1, `PMT8_OFS_CONTROL, 0);
    acc(1, `PMT8_OFS_COUNT, 32'h33); acc(0, `PMT8_OFS_COUNT, 0); chk("count", q, 32'h33);
    acc(0, 4'h2, 0); chk("bad addr", rs, `PMT8_RESP_SLVERR);
    acc(1, 4'h6, 32'h0); chk("bad wr addr", rs, `PMT8_RESP_SLVERR);
    $display("register test done");
    acc(1, `PMT8_OFS_PERIOD, 1);
    acc(1, `PMT8_OFS_COUNT, 0);
    for (i = 0; i < 4; i++) begin
      acc(1, `PMT8_OFS_CONTROL, 32'h4 | i);
      pw;
      pw;
      chk("gap", g + 1, 8 << (2 * i));
    end
    $display("prescale test done");
    for (i = 0; i < 16; i += 15) begin
      acc(1, `PMT8_OFS_CONTROL, 0);
      acc(1, `PMT8_OFS_COUNT, 0);
      acc(1, `PMT8_OFS_STATUS, 32'h101);
      acc(1, `PMT8_OFS_CONTROL, 32'h4 | (i << 3));
      p = 0;
      for (g = 0; g < 3000 && irq !== 1'b1; g++) begin @(negedge aclk); p += match_pulse; end
      if (g == 3000) begin miscompares++; results; end
      // the next match is at least 8 clocks away, so the tail only catches a pulse that lags the flag
      repeat (2) begin @(negedge aclk); p += match_pulse; end
      chk("post", p, i + 1);
    end
    acc(1, `PMT8_OFS_CONTROL, 0);
    acc(1, `PMT8_OFS_STATUS, 0);
    @(negedge aclk);
    chk("masked", irq, 0);
    acc(0, `PMT8_OFS_STATUS, 0); chk("flag", q[0], 1);
    acc(1, `PMT8_OFS_STATUS, 1); acc(0, `PMT8_OFS_STATUS, 0); chk("clear", q, 0);
    $display("interrupt test done");
    acc(1, `PMT8_OFS_CONTROL, 32'h4);
    sleep <= 1;
    acc(0, `PMT8_OFS_COUNT, 0);
    p = q;
    repeat (40) @(posedge aclk);
    acc(0, `PMT8_OFS_COUNT, 0); chk("sleep", q, p);
    $display("sleep test done");
    results;
  end
endmodule // period_match_timer8_test
